// *** common/tlbinv_pkg.sv ***
// constants, types and helpers shared by the stage 1 invalidation block
// assumes a 32-bit axi4-lite register bus and a single 100 MHz clock
package tlbinv_pkg;
  localparam int ENTRIES = 16;
  localparam int IDXW = 4;
  localparam int VAW = 32;
  localparam int IDW = 16;

  // register byte offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD_OP = 8'h04;
  localparam logic [7:0] REG_CMD_ID = 8'h08;
  localparam logic [7:0] REG_CMD_VA = 8'h0c;
  localparam logic [7:0] REG_CMD_GO = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_NEW_TAG = 8'h18;
  localparam logic [7:0] REG_NEW_ID = 8'h1c;
  localparam logic [7:0] REG_NEW_VA = 8'h20;
  localparam logic [7:0] REG_NEW_INS = 8'h24;
  localparam logic [7:0] REG_VALID_MAP = 8'h28;
  localparam logic [7:0] REG_EXEC_CNT = 8'h2c;

  // config bit positions and reset value
  localparam int CFG_S1 = 0;
  localparam int CFG_S2_NS = 1;
  localparam int CFG_S2_S = 2;
  localparam int CFG_S2_R = 3;
  localparam int CFG_HYP = 4;
  localparam int CFG_RME = 5;
  localparam int CFG_E2H = 6;
  localparam int CFG_R_E2H = 7;
  localparam logic [7:0] CFG_RESET = 8'h11;

  // command word fields
  localparam int OP_LSB = 0;
  localparam int Q_LSB = 4;
  localparam int LEAF_BIT = 8;
  localparam int ASID_LSB = 0;
  localparam int VM_IDENTIFIER_LSB = 16;
  localparam int TAG_GLOBAL = 4;
  localparam int TAG_LAST = 5;
  localparam int TAG_IDX_LSB = 8;
  localparam int ST_ERR_BIT = 0;
  localparam int ST_BUSY_BIT = 1;

  // opcodes
  localparam logic [3:0] OP_GUEST_ALL = 4'h0;
  localparam logic [3:0] OP_GUEST_ASID = 4'h1;
  localparam logic [3:0] OP_GUEST_VAA = 4'h2;
  localparam logic [3:0] OP_GUEST_VA = 4'h3;
  localparam logic [3:0] OP_MON_ALL = 4'h4;
  localparam logic [3:0] OP_MON_VA = 4'h5;
  localparam logic [3:0] OP_HYP_ALL = 4'h6;
  localparam logic [3:0] OP_HYP_VA = 4'h7;
  localparam logic [3:0] OP_HYP_VAA = 4'h8;
  localparam logic [3:0] OP_HYP_ASID = 4'h9;

  // command queue security states
  localparam logic [1:0] Q_NS = 2'h0;
  localparam logic [1:0] Q_S = 2'h1;
  localparam logic [1:0] Q_R = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    W_NS_EL1, W_NS_EL2, W_NS_E2H, W_S_EL1,
    W_EL3, W_R_EL1, W_R_EL2, W_R_E2H
  } tlbinv_world_t;

  function automatic logic [7:0] wbit(input tlbinv_world_t w);
    wbit = 8'h01 << w;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction
endpackage

// *** design/tlbinv_axil.sv ***
// axi4-lite slave front end for the invalidation block
// assumes the register file decodes and answers in the same cycle
`timescale 1ns/1ps
module tlbinv_axil
  import tlbinv_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // write channels
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // read channels
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // register file side
  output logic wr_en_out,
  output logic [31:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_err_in,
  output logic rd_en_out,
  output logic [31:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_err_in
);
  logic aw_held_r;
  logic w_held_r;

  assign s_axi_awready_out = !aw_held_r;
  assign s_axi_wready_out = !w_held_r;
  // write waits until the previous response is taken
  assign wr_en_out = aw_held_r && w_held_r && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign rd_en_out = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_addr_out = s_axi_araddr_in;

  always_ff @(posedge clock_in)
    if (!reset_n_in)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_addr_out <= 32'h0;
      wr_data_out <= 32'h0;
      wr_strb_out <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_held_r)
      begin
        aw_held_r <= 1'b1;
        wr_addr_out <= s_axi_awaddr_in;
      end
      else if (wr_en_out)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid_in && !w_held_r)
      begin
        w_held_r <= 1'b1;
        wr_data_out <= s_axi_wdata_in;
        wr_strb_out <= s_axi_wstrb_in;
      end
      else if (wr_en_out)
        w_held_r <= 1'b0;
    end

  always_ff @(posedge clock_in)
    if (!reset_n_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end
    else if (wr_en_out)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_err_in ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;

  always_ff @(posedge clock_in)
    if (!reset_n_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= RESP_OKAY;
    end
    else if (rd_en_out)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_data_in;
      s_axi_rresp_out <= rd_err_in ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
endmodule

// *** design/tlbinv_match.sv ***
// scope match of one cached translation entry against a command
// assumes the scope inputs are stable while the command executes
`timescale 1ns/1ps
module tlbinv_match
  import tlbinv_pkg::*;
(
  // entry
  input wire logic valid_in,
  input wire tlbinv_world_t world_in,
  input wire logic global_in,
  input wire logic last_in,
  input wire logic [IDW-1:0] vm_identifier_in,
  input wire logic [IDW-1:0] asid_in,
  input wire logic [VAW-1:0] va_in,
  // command scope
  input wire logic [7:0] world_mask_in,
  input wire logic use_vm_identifier_in,
  input wire logic use_asid_in,
  input wire logic use_va_in,
  input wire logic incl_global_in,
  input wire logic leaf_in,
  input wire logic [IDW-1:0] vm_identifier_cmd_in,
  input wire logic [IDW-1:0] asid_cmd_in,
  input wire logic [VAW-1:0] va_cmd_in,
  // result
  output logic hit_out
);
  logic tag_ok;

  // globals bypass the asid compare, non-globals need it when asked
  assign tag_ok = global_in ? incl_global_in
                            : (!use_asid_in || asid_in == asid_cmd_in);
  assign hit_out = valid_in && world_mask_in[world_in] && tag_ok &&
                   (!use_vm_identifier_in ||
                    vm_identifier_in == vm_identifier_cmd_in) &&
                   (!use_va_in || va_in == va_cmd_in) &&
                   (!leaf_in || last_in);
endmodule

// *** design/tlbinv_top.sv ***
// stage 1 translation cache with the invalidation command engine
// assumes axi4-lite software access and a synchronous active-low reset
//
// Contract
// RQ1: stage 2 only unit rejects all commands
// RQ2: monitor commands legal only on secure queue
// RQ3: realm management present rejects monitor commands
// RQ4: no hypervisor support rejects hypervisor commands
// RQ5: guest vm id matched only with stage 2
// RQ6: address range check optional, top byte ignored; the va compare here uses all 32 va bits
// RQ7: ns guest-all clears el1 of vm id
// RQ8: secure guest-all scope depends on secure stage 2
// RQ9: realm guest-all clears realm el1 of vm id
// RQ10: guest by asid spares global entries
// RQ11: guest by va covers all asids
// RQ12: guest by va also hits matching globals
// RQ13: leaf flag limits to last level entries
// RQ14: hypervisor-all clears both ns el2 kinds
// RQ15: secure and ns queue same hypervisor effect
// RQ16: realm hypervisor-all clears both realm el2 kinds
// RQ17: host extension on: asid or global match
// RQ18: host extension off: plain el2, asid ignored
// RQ19: software avoids unknown host extension bit
// RQ20: realm hypervisor by va uses realm el2
// RQ21: secure guest commands spare monitor entries
// RQ22: monitor commands clear monitor entries
// RQ23: illegal command changes nothing and halts
`timescale 1ns/1ps
module tlbinv_top
  import tlbinv_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_INVAL, ST_HALT}
    tlbinv_state_t;

  tlbinv_state_t state_r;
  logic wr_en, rd_en, wr_err, rd_err;
  logic [31:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [3:0] wr_strb;
  logic [7:0] cfg_r;
  logic [31:0] cmd_op_r, cmd_id_r, cmd_va_r;
  logic [31:0] new_tag_r, new_id_r, new_va_r;
  logic [31:0] exec_count_r;
  logic go, ack, ins;

  // entry store
  logic [ENTRIES-1:0] ent_valid_r, ent_global_r, ent_last_r, hit;
  tlbinv_world_t ent_world_r [ENTRIES];
  logic [IDW-1:0] ent_vm_identifier_r [ENTRIES];
  logic [IDW-1:0] ent_asid_r [ENTRIES];
  logic [VAW-1:0] ent_va_r [ENTRIES];

  // decoded command
  logic [3:0] op;
  logic [1:0] q;
  logic illegal, use_vm_identifier, use_asid, use_va, incl_global, leaf_eff;
  logic s2q, e2h;
  logic [7:0] wmask;
  logic [IDXW-1:0] ins_idx;

  tlbinv_axil u_axil (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_err_in(wr_err),
    .rd_en_out(rd_en),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_err_in(rd_err)
  );

  ////////////////////////////////////////////////////////////////////////
  // register file

  function automatic logic mapped(input logic [31:0] a);
    mapped = a[31:8] == 24'h0 && a[1:0] == 2'h0 && a[7:0] <= REG_EXEC_CNT;
  endfunction

  function automatic logic hit_reg(input logic [7:0] off);
    hit_reg = wr_en && mapped(wr_addr) && wr_addr[7:0] == off &&
              wr_strb != 4'h0;
  endfunction

  assign wr_err = !mapped(wr_addr);
  assign rd_err = !mapped(rd_addr);
  // a process, not assigns: the helper reads the bus signals itself,
  // so an assign would never wake up on them
  always_comb
  begin
    go = hit_reg(REG_CMD_GO) && state_r == ST_IDLE;
    ack = hit_reg(REG_STATUS) && wr_data[ST_ERR_BIT];
    ins = hit_reg(REG_NEW_INS);
  end
  assign ins_idx = new_tag_r[TAG_IDX_LSB +: IDXW];

  always_comb
  begin
    rd_data = 32'h0;
    case (rd_addr[7:0])
      REG_CFG: rd_data = {24'h0, cfg_r};
      REG_CMD_OP: rd_data = cmd_op_r;
      REG_CMD_ID: rd_data = cmd_id_r;
      REG_CMD_VA: rd_data = cmd_va_r;
      REG_STATUS: rd_data = {30'h0, state_r != ST_IDLE,
                             state_r == ST_HALT};
      REG_NEW_TAG: rd_data = new_tag_r;
      REG_NEW_ID: rd_data = new_id_r;
      REG_NEW_VA: rd_data = new_va_r;
      REG_VALID_MAP: rd_data = {{(32-ENTRIES){1'b0}}, ent_valid_r};
      REG_EXEC_CNT: rd_data = exec_count_r;
      default: rd_data = 32'h0;
    endcase
    if (rd_err)
      rd_data = 32'h0;
  end

  always_ff @(posedge clock_in)
    if (!reset_n_in)
      cfg_r <= CFG_RESET;
    else if (hit_reg(REG_CFG))
      cfg_r <= 8'(merge({24'h0, cfg_r}, wr_data, wr_strb));

  // command words are frozen while a command is in flight
  always_ff @(posedge clock_in)
    if (!reset_n_in)
    begin
      cmd_op_r <= 32'h0;
      cmd_id_r <= 32'h0;
      cmd_va_r <= 32'h0;
    end
    else if (state_r == ST_IDLE)
    begin
      if (hit_reg(REG_CMD_OP))
        cmd_op_r <= merge(cmd_op_r, wr_data, wr_strb);
      if (hit_reg(REG_CMD_ID))
        cmd_id_r <= merge(cmd_id_r, wr_data, wr_strb);
      if (hit_reg(REG_CMD_VA))
        cmd_va_r <= merge(cmd_va_r, wr_data, wr_strb);
    end

  always_ff @(posedge clock_in)
    if (!reset_n_in)
    begin
      new_tag_r <= 32'h0;
      new_id_r <= 32'h0;
      new_va_r <= 32'h0;
    end
    else
    begin
      if (hit_reg(REG_NEW_TAG))
        new_tag_r <= merge(new_tag_r, wr_data, wr_strb);
      if (hit_reg(REG_NEW_ID))
        new_id_r <= merge(new_id_r, wr_data, wr_strb);
      if (hit_reg(REG_NEW_VA))
        new_va_r <= merge(new_va_r, wr_data, wr_strb);
    end

  ////////////////////////////////////////////////////////////////////////
  // command decode

  assign op = cmd_op_r[OP_LSB +: 4];
  assign q = cmd_op_r[Q_LSB +: 2];

  always_comb
  begin
    illegal = 1'b0;
    wmask = 8'h00;
    use_vm_identifier = 1'b0;
    use_asid = 1'b0;
    use_va = 1'b0;
    incl_global = 1'b1;
    // vm id only matters with stage 2 for this queue's state
    s2q = q == Q_NS ? cfg_r[CFG_S2_NS] :
          q == Q_S ? cfg_r[CFG_S2_S] : cfg_r[CFG_S2_R]; // RQ5
    e2h = q == Q_R ? cfg_r[CFG_R_E2H] : cfg_r[CFG_E2H]; // RQ16 RQ20
    case (op)
      OP_GUEST_ALL, OP_GUEST_ASID, OP_GUEST_VAA, OP_GUEST_VA:
      begin
        // secure queue reaches secure el1 only, never monitor
        wmask = q == Q_NS ? wbit(W_NS_EL1) :
                q == Q_S ? wbit(W_S_EL1) : wbit(W_R_EL1); // RQ7 RQ9 RQ21
        use_vm_identifier = s2q; // RQ8
        use_asid = op == OP_GUEST_ASID || op == OP_GUEST_VA; // RQ12
        incl_global = op != OP_GUEST_ASID; // RQ10
        use_va = op == OP_GUEST_VAA || op == OP_GUEST_VA; // RQ11
      end
      OP_MON_ALL, OP_MON_VA:
      begin
        illegal = q != Q_S || cfg_r[CFG_RME]; // RQ2 RQ3
        wmask = wbit(W_EL3); // RQ22
        use_va = op == OP_MON_VA;
      end
      OP_HYP_ALL:
      begin
        illegal = !cfg_r[CFG_HYP]; // RQ4
        wmask = q == Q_R ? (wbit(W_R_EL2) | wbit(W_R_E2H))
                         : (wbit(W_NS_EL2) | wbit(W_NS_E2H)); // RQ14 RQ15
      end
      OP_HYP_VA, OP_HYP_VAA:
      begin
        illegal = !cfg_r[CFG_HYP]; // RQ4
        if (e2h)
          wmask = q == Q_R ? wbit(W_R_E2H) : wbit(W_NS_E2H); // RQ17
        else
          wmask = q == Q_R ? wbit(W_R_EL2) : wbit(W_NS_EL2); // RQ18
        use_asid = op == OP_HYP_VA && e2h; // RQ17 RQ18
        use_va = 1'b1;
      end
      OP_HYP_ASID:
      begin
        illegal = !cfg_r[CFG_HYP]; // RQ4
        wmask = q == Q_R ? wbit(W_R_E2H) : wbit(W_NS_E2H);
        use_asid = 1'b1;
        incl_global = 1'b0;
      end
      default: illegal = 1'b1;
    endcase
    if (q == 2'h3 || !cfg_r[CFG_S1])
      illegal = 1'b1; // RQ1
  end

  // va compare covers all 32 va bits, so the top byte counts too
  assign leaf_eff = cmd_op_r[LEAF_BIT] && use_va; // RQ6 RQ13

  ////////////////////////////////////////////////////////////////////////
  // command sequencing

  always_ff @(posedge clock_in)
    if (!reset_n_in)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_IDLE: if (go) state_r <= ST_CHECK;
        ST_CHECK: state_r <= illegal ? ST_HALT : ST_INVAL; // RQ23
        ST_INVAL: state_r <= ST_IDLE;
        ST_HALT: if (ack) state_r <= ST_IDLE; // RQ23
        default: state_r <= ST_IDLE;
      endcase

  always_ff @(posedge clock_in)
    if (!reset_n_in)
      exec_count_r <= 32'h0;
    else if (state_r == ST_INVAL)
      exec_count_r <= exec_count_r + 32'h1;

  ////////////////////////////////////////////////////////////////////////
  // entry store

  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_ent
    tlbinv_match u_match (
      .valid_in(ent_valid_r[i]),
      .world_in(ent_world_r[i]),
      .global_in(ent_global_r[i]),
      .last_in(ent_last_r[i]),
      .vm_identifier_in(ent_vm_identifier_r[i]),
      .asid_in(ent_asid_r[i]),
      .va_in(ent_va_r[i]),
      .world_mask_in(wmask),
      .use_vm_identifier_in(use_vm_identifier),
      .use_asid_in(use_asid),
      .use_va_in(use_va),
      .incl_global_in(incl_global),
      .leaf_in(leaf_eff),
      .vm_identifier_cmd_in(cmd_id_r[VM_IDENTIFIER_LSB +: IDW]),
      .asid_cmd_in(cmd_id_r[ASID_LSB +: IDW]),
      .va_cmd_in(cmd_va_r),
      .hit_out(hit[i])
    );

    // a fresh insert outranks a clear in the same cycle
    always_ff @(posedge clock_in)
      if (!reset_n_in)
        ent_valid_r[i] <= 1'b0;
      else if (ins && ins_idx == IDXW'(i))
        ent_valid_r[i] <= 1'b1;
      else if (state_r == ST_INVAL && hit[i])
        ent_valid_r[i] <= 1'b0; // RQ23

    always_ff @(posedge clock_in)
      if (!reset_n_in)
      begin
        ent_world_r[i] <= W_NS_EL1;
        ent_global_r[i] <= 1'b0;
        ent_last_r[i] <= 1'b0;
        ent_vm_identifier_r[i] <= '0;
        ent_asid_r[i] <= '0;
        ent_va_r[i] <= '0;
      end
      else if (ins && ins_idx == IDXW'(i))
      begin
        ent_world_r[i] <= tlbinv_world_t'(new_tag_r[2:0]);
        ent_global_r[i] <= new_tag_r[TAG_GLOBAL];
        ent_last_r[i] <= new_tag_r[TAG_LAST];
        ent_vm_identifier_r[i] <= new_id_r[VM_IDENTIFIER_LSB +: IDW];
        ent_asid_r[i] <= new_id_r[ASID_LSB +: IDW];
        ent_va_r[i] <= new_va_r;
      end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_check_illegal;
    state_r == ST_CHECK && illegal;
  endsequence
  // slot k is live and not refilled in the cycle a command executes
  sequence s_inval_at(int k);
    state_r == ST_INVAL && ent_valid_r[k] && !(ins && ins_idx == IDXW'(k));
  endsequence

  AST_S1_ABSENT: assert property ( // RQ1
    state_r == ST_CHECK && !cfg_r[CFG_S1] |=> state_r == ST_HALT)
    else $error("command accepted without stage 1");
  AST_MON_QUEUE: assert property ( // RQ2
    state_r == ST_CHECK && (op == OP_MON_ALL || op == OP_MON_VA) &&
    q != Q_S |=> state_r == ST_HALT)
    else $error("monitor command accepted off secure queue");
  AST_MON_RME: assert property ( // RQ3
    state_r == ST_CHECK && cfg_r[CFG_RME] &&
    (op == OP_MON_ALL || op == OP_MON_VA) |=> state_r == ST_HALT)
    else $error("monitor command accepted with realm management");
  AST_HYP_ABSENT: assert property ( // RQ4
    state_r == ST_CHECK && !cfg_r[CFG_HYP] && op >= OP_HYP_ALL &&
    op <= OP_HYP_ASID |=> state_r == ST_HALT)
    else $error("hypervisor command accepted without support");
  AST_ILL_HALTS: assert property ( // RQ23
    s_check_illegal ##1 (state_r == ST_HALT && !ack && !ins)
    |=> state_r == ST_HALT && ent_valid_r == $past(ent_valid_r))
    else $error("queue resumed before error acknowledge");
  AST_NS_GUEST_ALL: assert property ( // RQ7
    s_inval_at(0) and (op == OP_GUEST_ALL && q == Q_NS &&
    ent_world_r[0] == W_NS_EL1 && (!s2q ||
    ent_vm_identifier_r[0] == cmd_id_r[VM_IDENTIFIER_LSB +: IDW]))
    |=> !ent_valid_r[0])
    else $error("guest-all left a matching el1 entry");
  // each check watches its own slot, so one fill shows every entry kind
  AST_GUEST_SPARES_HYP: assert property ( // RQ7
    s_inval_at(5) and (op <= OP_GUEST_VA &&
    (ent_world_r[5] == W_NS_EL2 || ent_world_r[5] == W_NS_E2H))
    |=> ent_valid_r[5])
    else $error("guest command removed a hypervisor entry");
  AST_ASID_SPARES_GLOBAL: assert property ( // RQ10
    s_inval_at(2) and (op == OP_GUEST_ASID && ent_global_r[2])
    |=> ent_valid_r[2])
    else $error("guest by asid removed a global entry");
  AST_LEAF_ONLY: assert property ( // RQ13
    s_inval_at(3) and (cmd_op_r[LEAF_BIT] && use_va && !ent_last_r[3])
    |=> ent_valid_r[3])
    else $error("leaf command removed a non-leaf entry");
  AST_MON_ALL: assert property ( // RQ22
    s_inval_at(9) and (op == OP_MON_ALL && ent_world_r[9] == W_EL3)
    |=> !ent_valid_r[9])
    else $error("monitor-all left a monitor entry");
endmodule

// *** testbench/stage1_tlb_invalidate_cmds_bench.sv ***
// bench for the stage 1 invalidation block, driven over axi4-lite
// assumes assertions live in the design; fills all 16 entries per case
`timescale 1ns/1ps
module stage1_tlb_invalidate_cmds_bench
  import tlbinv_pkg::*;
;
  logic clock_in = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fails = 0, checks = 0, cyc = 0, ecnt = 0;
  localparam logic [31:0] VA = 32'h0000_1234, VB = 32'h0000_5678;
  localparam logic [31:0] V1 = 32'h0001_0005;
  // entry table: world, asid, then global/last/va-b/vm-2 masks
  localparam logic [2:0] EW [16] = '{0,0,0,0,0,1,2,2,3,4,4,5,6,7,2,3};
  localparam logic [15:0] EAS [16] = '{5,5,7,5,6,0,5,9,5,0,0,5,0,5,6,3};
  localparam logic [15:0] GM = 16'h8084, LM = 16'hfff7;
  localparam logic [15:0] VBM = 16'h9430, V2M = 16'h8002;

  tlbinv_top i_dut (.clock_in(clock_in), .reset_n_in(reset_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));

  initial
  begin
    forever #5 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly 10.5k cycles the cases need
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus access; ready is judged at the falling edge, where it is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic pa, pw, t;
    pa = 1;
    pw = 1;
    @(posedge clock_in);
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw)
    begin
      @(negedge clock_in);
      t = pa && awready === 1'b1;
      pw = pw && wready !== 1'b1;
      @(posedge clock_in);
      if (t) awvalid <= 0;
      if (!pw) wvalid <= 0;
      pa = pa && !t;
    end
    do
    begin
      @(negedge clock_in);
      t = bvalid;
      r = bresp;
      @(posedge clock_in);
    end while (t !== 1'b1);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic t;
    @(posedge clock_in);
    araddr <= {24'h0, a};
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(negedge clock_in);
      t = arready;
      @(posedge clock_in);
    end while (t !== 1'b1);
    arvalid <= 0;
    do
    begin
      @(negedge clock_in);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock_in);
    end while (t !== 1'b1);
    rready <= 0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one case: refill the cache, run one command, compare what is left
  task automatic sc(input logic [7:0] cfg, input logic [3:0] op,
                    input logic [1:0] q, input logic leaf,
                    input logic [31:0] id, input logic [31:0] va,
                    input logic err, input logic [15:0] map);
    logic [31:0] d, s;
    logic [1:0] r;
    int n;
    wr(REG_CFG, {24'h0, cfg}, r);
    for (int i = 0; i < 16; i++)
    begin
      wr(REG_NEW_TAG, {20'h0, i[3:0], 2'b00, LM[i], GM[i], 1'b0, EW[i]}, r);
      wr(REG_NEW_ID, {V2M[i] ? 16'h0002 : 16'h0001, EAS[i]}, r);
      wr(REG_NEW_VA, VBM[i] ? VB : VA, r);
      wr(REG_NEW_INS, 32'h0, r);
    end
    rd(REG_VALID_MAP, d, r);
    chk("filled map", d, 32'h0000ffff);
    wr(REG_CMD_OP, {23'h0, leaf, 2'b00, q, op}, r);
    wr(REG_CMD_ID, id, r);
    wr(REG_CMD_VA, va, r);
    wr(REG_CMD_GO, 32'h1, r);
    chk("go bresp", 32'(r), 32'(RESP_OKAY));
    n = 0;
    do
    begin
      rd(REG_STATUS, s, r);
      n++;
    end while (s[ST_BUSY_BIT] === 1'b1 && s[ST_ERR_BIT] !== 1'b1 && n < 40);
    chk("error flag", 32'(s[ST_ERR_BIT]), 32'(err));
    chk("busy flag", 32'(s[ST_BUSY_BIT]), 32'(err));
    rd(REG_VALID_MAP, d, r);
    chk("valid map", d, {16'h0, map});
    if (err)
    begin
      wr(REG_STATUS, 32'h1, r);
      rd(REG_STATUS, s, r);
      chk("status after ack", s, 32'h0);
    end
    else
      ecnt++;
    rd(REG_EXEC_CNT, d, r);
    chk("exec count", d, 32'(ecnt));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge clock_in);
    reset_n <= 1;
    rd(REG_CFG, d, r);
    chk("cfg reset", d, 32'(CFG_RESET));
    rd(REG_VALID_MAP, d, r);
    chk("map reset", d, 32'h0);
    rd(8'h30, d, r);
    chk("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
    wr(8'h34, 32'h1, r);
    chk("unmapped bresp", 32'(r), 32'(RESP_SLVERR));
    sc(8'h13, OP_GUEST_ALL, Q_NS, 0, V1, VA, 0, 16'hffe2);
    sc(8'h13, OP_GUEST_ASID, Q_NS, 0, V1, VA, 0, 16'hfff6);
    sc(8'h13, OP_GUEST_VAA, Q_NS, 0, V1, VA, 0, 16'hfff2);
    sc(8'h13, OP_GUEST_VA, Q_NS, 1, V1, VA, 0, 16'hfffa);
    sc(8'h13, OP_GUEST_ALL, Q_S, 0, V1, VA, 0, 16'h7eff);
    sc(8'h17, OP_GUEST_ALL, Q_S, 0, V1, VA, 0, 16'hfeff);
    sc(8'h1b, OP_GUEST_ALL, Q_R, 0, V1, VA, 0, 16'hf7ff);
    sc(8'h13, OP_MON_ALL, Q_S, 0, V1, VA, 0, 16'hf9ff);
    sc(8'h13, OP_MON_VA, Q_S, 0, V1, VA, 0, 16'hfdff);
    sc(8'h13, OP_HYP_ALL, Q_NS, 0, V1, VA, 0, 16'hbf1f);
    sc(8'h13, OP_HYP_ALL, Q_S, 0, V1, VA, 0, 16'hbf1f);
    sc(8'h13, OP_HYP_ALL, Q_R, 0, V1, VA, 0, 16'hcfff);
    sc(8'h53, OP_HYP_VA, Q_NS, 0, V1, VA, 0, 16'hff3f);
    sc(8'h53, OP_HYP_VAA, Q_NS, 0, V1, VA, 0, 16'hbf3f);
    sc(8'h53, OP_HYP_ASID, Q_S, 0, V1, VA, 0, 16'hffbf);
    sc(8'h13, OP_HYP_VA, Q_NS, 0, 32'h0001_0009, VB, 0, 16'hffdf);
    sc(8'h93, OP_HYP_VA, Q_R, 0, V1, VA, 0, 16'hdfff);
    sc(8'h13, OP_MON_ALL, Q_NS, 0, V1, VA, 1, 16'hffff);
    sc(8'h13, OP_MON_VA, Q_R, 0, V1, VA, 1, 16'hffff);
    sc(8'h33, OP_MON_ALL, Q_S, 0, V1, VA, 1, 16'hffff);
    sc(8'h13, 4'ha, Q_NS, 0, V1, VA, 1, 16'hffff);
    sc(8'h13, OP_GUEST_ALL, 2'h3, 0, V1, VA, 1, 16'hffff);
    for (int k = 0; k < 4; k++)
      sc(8'h03, 4'(OP_HYP_ALL + k), Q_NS, 0, V1, VA, 1, 16'hffff);
    for (int k = 0; k < 10; k++)
      sc(8'h12, 4'(k), Q_S, 0, V1, VA, 1, 16'hffff);
    tally_and_finish;
  end
endmodule
